//--- core/qddr_read_slave.sv
// device side of the four-lane double-data-rate read command of a serial flash
// assumes serial pins arrive asynchronously and the array answers MEM_DATA_I
// combinationally from MEM_ADDR_O on the system clock
//
// Summary of operation
// RQ1 - read code EDh takes 3 or 4 address bytes
// RQ2 - read code EEh always takes 4 address bytes
// RQ3 - read accepted only when quad enable set; the code checks it only when decoding the command, not in continuous frames
// RQ4 - address arrives one nibble per clock edge
// RQ5 - mode byte follows, then data nibbles per edge
// RQ6 - host keeps serial clock within allowed rate
// RQ7 - dummy clocks inserted, count from latency code
// RQ8 - standard or enhanced table, both reserving mode
// RQ9 - host releases lanes during dummy when pattern used
// RQ10 - complementary mode nibbles enter continuous mode
// RQ11 - other mode values leave continuous at reselect
// RQ12 - short invalid frame releases continuous mode
// RQ13 - address steps by one per data byte
// RQ14 - top address wraps to zero, read continues
// RQ15 - host keeps select low through mode, dummy
// RQ16 - transfer pause input ignored during this read
// RQ17 - pattern preamble on four clocks before data
// RQ18 - host releases lanes before the preamble
// RQ19 - pattern bit driven identically on every lane
// RQ20 - host trains sampling point during preamble
// RQ21 - nibbles msb first, lane three highest bit
// RQ22 - mode byte fills one clock after address
`timescale 1ns/100ps
module qddr_read_slave
    import qddr_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic SCK_I,
    input wire logic CS_N_I,
    input wire logic [3:0] IO_I,
    input wire cfg_t CFG_I,
    input wire logic [7:0] MEM_DATA_I,
    output logic [3:0] IO_O,
    output logic [3:0] IO_OE_O,
    output logic [ADDR_W-1:0] MEM_ADDR_O,
    output logic MEM_RD_O,
    output logic CONT_MODE_O
);
    logic [5:0] pin_q;
    logic [5:0] pin_rise;
    logic [5:0] pin_fall;

    // sampling at 40 MHz keeps usable serial clock far below the command limit
    edge_sync #(.W(6)) u_pins ( // RQ6
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .d_i({SCK_I, CS_N_I, IO_I}),
        .q_o(pin_q),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic cs_act;
    logic [3:0] io;

    assign sck_rise = pin_rise[5];
    assign sck_fall = pin_fall[5];
    assign cs_rise = pin_rise[4];
    assign cs_fall = pin_fall[4];
    assign cs_act = ~pin_q[4];
    assign io = pin_q[3:0];

    state_t st_r;
    state_t st_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [31:0] sh_r;
    logic [31:0] sh_nxt;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic four_r;
    logic four_nxt;
    logic cont_r;
    logic cont_nxt;
    logic reached_r;
    logic reached_nxt;
    logic [3:0] rises_r;
    logic [3:0] rises_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [7:0] data_r;
    logic [7:0] data_nxt;
    logic nib_r;
    logic nib_nxt;
    logic [5:0] d2_r;
    logic [5:0] d2_nxt;
    logic [3:0] io_o_r;
    logic [3:0] io_o_nxt;
    logic [3:0] oe_r;
    logic [3:0] oe_nxt;
    logic rd_r;
    logic rd_nxt;

    // preamble slot for the value presented after dummy edge e of d2 edges
    function automatic logic [1:0] pre_bit(input logic [5:0] e, input logic [5:0] d2,
                                           input logic [7:0] pat);
        logic [6:0] s;
        logic ok;
        s = {1'b0, e} + PRE_EDGES - {1'b0, d2};
        ok = (e < d2) && (({1'b0, e} + PRE_EDGES) >= {1'b0, d2});
        return {ok, pat[~s[2:0]]};
    endfunction

    // scratch values shared by several states, set at the top of the process
    logic [7:0] code;
    logic [31:0] addr_word;
    logic [5:0] last_nib;
    logic [5:0] e;
    logic [1:0] pb;
    logic [7:0] mode_new;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        mode_nxt = mode_r;
        four_nxt = four_r;
        cont_nxt = cont_r;
        reached_nxt = reached_r;
        rises_nxt = rises_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        nib_nxt = nib_r;
        d2_nxt = d2_r;
        io_o_nxt = io_o_r;
        oe_nxt = oe_r;
        rd_nxt = 1'b0;
        code = {sh_r[6:0], io[0]};
        addr_word = {sh_r[27:0], io};
        last_nib = four_r ? ADDR_LAST_NIB_4 : ADDR_LAST_NIB_3;
        e = cnt_r + 6'h01;
        pb = 2'b00;
        mode_new = {mode_r[3:0], io};
        if (cs_rise) begin
            st_nxt = ST_IDLE;
            oe_nxt = 4'h0;
            if (reached_r) begin
                cont_nxt = (mode_r[7:4] == ~mode_r[3:0]); // RQ10 RQ11
            end else if (cont_r && (rises_r <= SHORT_FRAME_CLKS)) begin
                cont_nxt = 1'b0; // RQ12
            end
            // select raised inside dummy lets the mode byte set continuous state; raised inside mode it clears it
        end else if (cs_fall) begin
            st_nxt = cont_r ? ST_ADDR : ST_CMD; // RQ10
            // counters restart so a cut frame cannot leak into the next one
            cnt_nxt = 6'h00;
            sh_nxt = ADDR_RESET;
            rises_nxt = 4'h0;
            reached_nxt = 1'b0;
            oe_nxt = 4'h0;
        end else if (cs_act && (sck_rise || sck_fall)) begin
            // rising edges saturate so a long frame never looks short
            if (sck_rise && (rises_r != RISE_SAT)) begin
                rises_nxt = rises_r + 4'h1;
            end
            // the pause pin has no port: no phase can be held off
            case (st_r) // RQ16
                ST_CMD: begin
                    if (sck_rise) begin
                        sh_nxt = {sh_r[30:0], io[0]};
                        cnt_nxt = e;
                        if (cnt_r == CMD_LAST_BIT) begin
                            cnt_nxt = 6'h00;
                            sh_nxt = ADDR_RESET;
                            if (CFG_I.quad_en && // RQ3
                                ((code == CMD_READ_3OR4) || (code == CMD_READ_4))) begin
                                st_nxt = ST_ADDR;
                                // width is kept for the continuous frames that follow
                                four_nxt = (code == CMD_READ_4) || // RQ2
                                    CFG_I.extended_address_mode; // RQ1
                            end else begin
                                st_nxt = ST_SKIP;
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    // first nibble lands on a rising edge, then every edge
                    if (sck_rise || (cnt_r != 6'h00)) begin
                        sh_nxt = addr_word; // RQ4 RQ21
                        cnt_nxt = e;
                        if (cnt_r == last_nib) begin // RQ1 RQ2
                            st_nxt = ST_MODE;
                            cnt_nxt = 6'h00;
                            addr_nxt = addr_word[ADDR_W-1:0];
                        end
                    end
                end
                ST_MODE: begin
                    if (sck_rise || (cnt_r != 6'h00)) begin
                        mode_nxt = mode_new; // RQ5 RQ22
                        cnt_nxt = e;
                        if (cnt_r == MODE_LAST_NIB) begin
                            st_nxt = ST_DUMMY;
                            cnt_nxt = 6'h00;
                            reached_nxt = 1'b1;
                            d2_nxt = {1'b0, lat_cycles(CFG_I), 1'b0}; // RQ7 RQ8
                            pb = pre_bit(6'h00, {1'b0, lat_cycles(CFG_I), 1'b0},
                                         CFG_I.data_learning_pattern);
                            if (CFG_I.dlp_en && pb[1]) begin
                                io_o_nxt = {4{pb[0]}}; // RQ17 RQ19
                                oe_nxt = 4'hF; // RQ18
                            end
                        end
                    end
                end
                ST_DUMMY: begin
                    cnt_nxt = e;
                    // pattern fills only the last eight dummy edges; short latency trims its head
                    if (e == d2_r) begin // RQ7
                        st_nxt = ST_DATA;
                        data_nxt = MEM_DATA_I;
                        rd_nxt = 1'b1;
                        io_o_nxt = MEM_DATA_I[7:4]; // RQ5 RQ21
                        oe_nxt = 4'hF;
                        nib_nxt = 1'b1;
                    end else begin
                        pb = pre_bit(e, d2_r, CFG_I.data_learning_pattern);
                        if (CFG_I.dlp_en && pb[1]) begin
                            io_o_nxt = {4{pb[0]}}; // RQ17 RQ19
                            oe_nxt = 4'hF; // RQ9
                        end else begin
                            oe_nxt = 4'h0;
                        end
                    end
                end
                ST_DATA: begin
                    if (nib_r) begin
                        io_o_nxt = data_r[3:0]; // RQ21
                        // counter width is the array size, so the top address rolls to zero
                        addr_nxt = addr_r + 1'b1; // RQ13 RQ14
                        nib_nxt = 1'b0;
                    end else begin
                        // next byte is addressed one edge ahead so its high nibble is ready in time
                        data_nxt = MEM_DATA_I;
                        rd_nxt = 1'b1;
                        io_o_nxt = MEM_DATA_I[7:4]; // RQ5
                        nib_nxt = 1'b1;
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    st_nxt = st_r;
                end
                default: begin
                    st_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // synchronous reset only, so every register stays a plain flop
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            st_r <= ST_IDLE;
            cnt_r <= 6'h00;
            sh_r <= ADDR_RESET;
            mode_r <= MODE_RESET;
            four_r <= 1'b0;
            cont_r <= 1'b0;
            reached_r <= 1'b0;
            rises_r <= 4'h0;
            addr_r <= '0;
            data_r <= 8'h00;
            nib_r <= 1'b0;
            d2_r <= 6'h00;
            io_o_r <= 4'h0;
            oe_r <= 4'h0;
            rd_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            mode_r <= mode_nxt;
            four_r <= four_nxt;
            cont_r <= cont_nxt;
            reached_r <= reached_nxt;
            rises_r <= rises_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            nib_r <= nib_nxt;
            d2_r <= d2_nxt;
            io_o_r <= io_o_nxt;
            oe_r <= oe_nxt;
            rd_r <= rd_nxt;
        end
    end

    assign IO_O = io_o_r;
    assign IO_OE_O = oe_r;
    assign MEM_ADDR_O = addr_r;
    assign MEM_RD_O = rd_r;
    assign CONT_MODE_O = cont_r;
endmodule

//--- core/qddr_pkg.sv
// constants, configuration carrier and state encoding for the quad ddr read slave
// assumes a single 40 MHz system clock; serial pins are sampled, not clocked on
package qddr_pkg;

    localparam logic [7:0] CMD_READ_3OR4 = 8'hED;
    localparam logic [7:0] CMD_READ_4 = 8'hEE;

    localparam logic [5:0] CMD_LAST_BIT = 6'h07;
    localparam logic [5:0] ADDR_LAST_NIB_3 = 6'h05;
    localparam logic [5:0] ADDR_LAST_NIB_4 = 6'h07;
    localparam logic [5:0] MODE_LAST_NIB = 6'h01;
    localparam logic [6:0] PRE_EDGES = 7'h08;
    localparam logic [3:0] SHORT_FRAME_CLKS = 4'h8;
    localparam logic [3:0] RISE_SAT = 4'hF;

    localparam int CLK_MHZ = 40;
    localparam int SCK_MAX_MHZ = 80;

    // dummy clocks per latency code, plain defaults
    localparam logic [3:0] LAT_STD_0 = 4'h5;
    localparam logic [3:0] LAT_STD_1 = 4'h6;
    localparam logic [3:0] LAT_STD_2 = 4'h7;
    localparam logic [3:0] LAT_STD_3 = 4'h4;
    localparam logic [3:0] LAT_ENH_0 = 4'h6;
    localparam logic [3:0] LAT_ENH_1 = 4'h4;
    localparam logic [3:0] LAT_ENH_2 = 4'h5;
    localparam logic [3:0] LAT_ENH_3 = 4'h8;

    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [7:0] MODE_RESET = 8'h00;

    typedef struct packed {
        logic quad_en;
        logic extended_address_mode;
        logic [1:0] latency_code;
        logic enhanced_latency_table;
        logic dlp_en;
        logic [7:0] data_learning_pattern;
    } cfg_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_CMD = 7'b000_0010,
        ST_ADDR = 7'b000_0100,
        ST_MODE = 7'b000_1000,
        ST_DUMMY = 7'b001_0000,
        ST_DATA = 7'b010_0000,
        ST_SKIP = 7'b100_0000
    } state_t;

    function automatic logic [3:0] lat_cycles(input cfg_t c);
        logic [3:0] v;
        v = LAT_STD_0;
        case ({c.enhanced_latency_table, c.latency_code})
            3'b000: v = LAT_STD_0;
            3'b001: v = LAT_STD_1;
            3'b010: v = LAT_STD_2;
            3'b011: v = LAT_STD_3;
            3'b100: v = LAT_ENH_0;
            3'b101: v = LAT_ENH_1;
            3'b110: v = LAT_ENH_2;
            3'b111: v = LAT_ENH_3;
            default: v = LAT_STD_0;
        endcase
        return v;
    endfunction

endpackage

//--- core/edge_sync.sv
// two-flop synchroniser with rise and fall detection on the synced value
// assumes inputs are asynchronous pins; all bits share one delay so they stay aligned
`timescale 1ns/100ps
module edge_sync #(
    parameter int W = 6
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] last_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_nxt;
    logic [W-1:0] last_nxt;

    always_comb begin
        meta_nxt = d_i;
        sync_nxt = meta_r;
        last_nxt = sync_r;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_r <= '1;
            sync_r <= '1;
            last_r <= '1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            last_r <= last_nxt;
        end
    end

    // edges look only at the second and third stages, never at the first
    assign q_o = sync_r;
    assign rise_o = sync_r & ~last_r;
    assign fall_o = ~sync_r & last_r;
endmodule

//--- tb/qddr_read_slave_monitor.sv
// concurrent checks on the ports of the quad ddr read slave
// bound to the design top; one clock domain, synchronous active-low reset
`timescale 1ns/100ps
module qddr_read_slave_monitor
    import qddr_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic SCK_I,
    input wire logic CS_N_I,
    input wire logic [3:0] IO_I,
    input wire cfg_t CFG_I,
    input wire logic [7:0] MEM_DATA_I,
    input wire logic [3:0] IO_O,
    input wire logic [3:0] IO_OE_O,
    input wire logic [ADDR_W-1:0] MEM_ADDR_O,
    input wire logic MEM_RD_O,
    input wire logic CONT_MODE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    property p_oe_pair; IO_OE_O != 4'h0 |-> IO_OE_O == 4'hF; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("lane enables differ");
    property p_quad_off; (!CFG_I.quad_en) [*8] |-> IO_OE_O == 4'h0; endproperty
    a_quad_off: assert property (p_quad_off) else $error("lanes driven while disabled");
    property p_cs_idle; CS_N_I [*5] |-> IO_OE_O == 4'h0; endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("lanes driven while deselected");
    // a lane value moves only three samples after the serial clock pin moved
    property p_io_hold; $changed(IO_O) |-> $past(SCK_I, 3) != $past(SCK_I, 4); endproperty
    a_io_hold: assert property (p_io_hold) else $error("lane value moved without an edge");
    property p_preamble; $rose(IO_OE_O[0]) && CFG_I.dlp_en |->
        IO_O == {4{CFG_I.data_learning_pattern[7]}}; endproperty
    a_preamble: assert property (p_preamble) else $error("preamble start wrong");
    property p_rd_nib; MEM_RD_O |-> ##[0:1] (IO_O == MEM_DATA_I[7:4]); endproperty
    a_rd_nib: assert property (p_rd_nib) else $error("high nibble not first");
    // a byte fetched just before select rises never reaches its low-nibble edge, so it needs no step
    property p_rd_step; MEM_RD_O ##1 (!CS_N_I) [*4] |-> ##[0:4] $changed(MEM_ADDR_O);
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("address did not step");
    property p_addr_step; $past(IO_OE_O) == 4'hF && IO_OE_O == 4'hF && $changed(MEM_ADDR_O)
        |-> MEM_ADDR_O == ADDR_W'($past(MEM_ADDR_O) + 1'b1); endproperty
    a_addr_step: assert property (p_addr_step) else $error("address step not one");
    property p_cont_upd; $changed(CONT_MODE_O) |-> $past(CS_N_I) && $past(CS_N_I, 2); endproperty
    a_cont_upd: assert property (p_cont_upd) else $error("mode flag moved in frame");
    c_cont_on: cover property ($rose(CONT_MODE_O));
    c_cont_off: cover property ($fell(CONT_MODE_O));
    c_wrap: cover property (MEM_ADDR_O == '0 && $past(MEM_ADDR_O) == '1);
endmodule
bind qddr_read_slave qddr_read_slave_monitor #(.ADDR_W(ADDR_W)) mon (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I), .IO_I(IO_I),
    .CFG_I(CFG_I), .MEM_DATA_I(MEM_DATA_I), .IO_O(IO_O), .IO_OE_O(IO_OE_O),
    .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_O(MEM_RD_O), .CONT_MODE_O(CONT_MODE_O)
);

//--- tb/qddr_host.sv
// host controller model issuing quad ddr reads, mode 0, 200 ns serial period
// assumes the bench resolves the shared lanes and calls the tasks at a falling clock edge
`timescale 1ns/100ps
module qddr_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic [3:0] io_o,
    output logic io_oe_o,
    input wire logic [3:0] io_i
);
    logic [3:0] cap [$];
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h0;
        io_oe_o = 1'b0;
    end
    // lanes change midway between edges so each edge sees 50 ns of settled data
    task automatic frame(input bit use_cmd, input logic [7:0] cmd, input int nnib,
                         input logic [31:0] a, input logic [7:0] mode, input int nrd);
        logic [39:0] sh;
        cap.delete();
        sh = {a, mode} << (4 * (8 - nnib));
        cs_n_o = 1'b0;
        io_oe_o = 1'b1;
        #100;
        if (use_cmd) for (int i = 7; i >= 0; i--) begin
            io_o = {3'h0, cmd[i]};
            #50 sck_o = 1'b1;
            #100 sck_o = 1'b0;
            #50;
        end
        for (int i = 0; i < nnib + 2; i++) begin
            io_o = sh[39:36];
            sh = sh << 4;
            #50 sck_o = ~sck_o;
            #50;
        end
        io_oe_o = 1'b0;
        for (int i = 0; i < nrd; i++) begin
            #50 cap.push_back(io_i);
            sck_o = ~sck_o;
            #50;
        end
        #100 cs_n_o = 1'b1;
        #300;
    endtask
    task automatic short_frame(input int nclk);
        cs_n_o = 1'b0;
        io_oe_o = 1'b1;
        io_o = 4'h0;
        #100;
        repeat (nclk) begin
            #50 sck_o = 1'b1;
            #100 sck_o = 1'b0;
            #50;
        end
        #100 cs_n_o = 1'b1;
        #300;
    endtask
endmodule

//--- tb/tb_qddr_read_slave.sv
// self-checking bench for the quad ddr read slave with a host model and array stub
// assumes the array answers combinationally; a released lane shows a churning value
`timescale 1ns/100ps
module tb_qddr_read_slave;
    import qddr_pkg::*;
    logic CLK_I = 1'b0;
    logic NRST_I = 1'b0;
    cfg_t cfg = '{1'b1, 1'b0, 2'h0, 1'b0, 1'b1, 8'h34};
    logic [3:0] churn = 4'h0;
    logic oe_seen = 1'b0;
    int n_fail = 0;
    int n_tests = 0;
    wire logic sck, cs_n, host_oe, mem_rd, cont;
    wire logic [3:0] io_o, io_oe, host_io, io_bus;
    wire logic [23:0] mem_addr;
    wire logic [7:0] mem_data;
    logic [3:0] lat_tab [8] = '{LAT_STD_0, LAT_STD_1, LAT_STD_2, LAT_STD_3,
                                LAT_ENH_0, LAT_ENH_1, LAT_ENH_2, LAT_ENH_3};
    function automatic logic [7:0] mem_f(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
    endfunction
    assign mem_data = mem_f(mem_addr);
    assign io_bus = io_oe[0] ? io_o : (host_oe ? host_io : churn);
    always #12.5 CLK_I = ~CLK_I;
    always @(posedge CLK_I) churn <= churn + 4'h5;
    always @(posedge CLK_I) if (io_oe !== 4'h0) oe_seen <= 1'b1;
    qddr_read_slave dut (.CLK_I(CLK_I), .NRST_I(NRST_I), .SCK_I(sck), .CS_N_I(cs_n),
        .IO_I(io_bus), .CFG_I(cfg), .MEM_DATA_I(mem_data), .IO_O(io_o), .IO_OE_O(io_oe),
        .MEM_ADDR_O(mem_addr), .MEM_RD_O(mem_rd), .CONT_MODE_O(cont));
    qddr_host host (.sck_o(sck), .cs_n_o(cs_n), .io_o(host_io), .io_oe_o(host_oe),
        .io_i(io_bus));
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected data at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // the preamble is checked in every read that runs with the pattern on
    task automatic rd(input bit use_cmd, input logic [7:0] cmd, input int nnib,
                      input logic [31:0] a, input logic [7:0] mode, input int nb);
        int d;
        d = lat_tab[{cfg.enhanced_latency_table, cfg.latency_code}];
        host.frame(use_cmd, cmd, nnib, a, mode, 2 * d + 2 * nb);
        for (int j = 0; (j < 8) && cfg.dlp_en; j++) begin
            chk_data({4'h0, host.cap[2*d-8+j]}, {4'h0, {4{cfg.data_learning_pattern[7-j]}}});
        end
        for (int b = 0; b < nb; b++) begin
            chk_data({host.cap[2*d+2*b], host.cap[2*d+2*b+1]}, mem_f(a[23:0] + 24'(b)));
        end
    endtask
    task automatic t_latency();
        for (int i = 0; i < 8; i++) begin
            cfg.enhanced_latency_table = i[2];
            cfg.latency_code = i[1:0];
            rd(1'b1, CMD_READ_3OR4, 6, 32'h0012_3400 + i, 8'h00, 2);
        end
    endtask
    task automatic t_addr_width();
        cfg.extended_address_mode = 1'b1;
        rd(1'b1, CMD_READ_3OR4, 8, 32'h5A00_0F10, 8'h00, 2);
        cfg.extended_address_mode = 1'b0;
        rd(1'b1, CMD_READ_4, 8, 32'hC300_7F0E, 8'h00, 2);
        cfg.dlp_en = 1'b0;
        rd(1'b1, CMD_READ_4, 8, 32'h0100_0020, 8'h00, 2);
        cfg.dlp_en = 1'b1;
    endtask
    task automatic t_cont();
        rd(1'b1, CMD_READ_3OR4, 6, 32'h0000_1000, 8'h5A, 1);
        chk_flag(cont, 1'b1);
        rd(1'b0, 8'h00, 6, 32'h0000_2000, 8'hA5, 1);
        chk_flag(cont, 1'b1);
        rd(1'b0, 8'h00, 6, 32'h0000_3000, 8'h55, 1);
        chk_flag(cont, 1'b0);
        rd(1'b1, CMD_READ_3OR4, 6, 32'h0000_4000, 8'h00, 1);
    endtask
    task automatic t_short();
        rd(1'b1, CMD_READ_3OR4, 6, 32'h0000_5000, 8'h96, 1);
        chk_flag(cont, 1'b1);
        host.short_frame(3);
        chk_flag(cont, 1'b0);
    endtask
    task automatic t_refuse();
        oe_seen = 1'b0;
        cfg.quad_en = 1'b0;
        host.frame(1'b1, CMD_READ_3OR4, 6, 32'h0000_0100, 8'h00, 20);
        chk_flag(oe_seen, 1'b0);
        cfg.quad_en = 1'b1;
        oe_seen = 1'b0;
        host.frame(1'b1, 8'hEB, 6, 32'h0000_0100, 8'h00, 20);
        chk_flag(oe_seen, 1'b0);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (2) @(negedge CLK_I);
        NRST_I = 1'b1;
        repeat (4) @(negedge CLK_I);
        t_latency();
        t_addr_width();
        t_cont();
        t_short();
        rd(1'b1, CMD_READ_3OR4, 6, 32'h00FF_FFFF, 8'h00, 2);
        t_refuse();
        finish_test();
    end
endmodule
